// ===== rtl/alarm_irq_control.sv
// Command byte, alarm flags and interrupt line control of the timekeeper.
//
// Behaviour
// - Copy-allow at 1 lets the running counters refresh the visible time registers.
// - Copy-allow at 0 freezes the visible time registers; counters keep running.
// - Pin-swap at 1 puts time-of-day on line A and watchdog on line B.
// - Pin-swap at 0 puts time-of-day on line B and watchdog on line A.
// - A pin-swap change moves interrupts at once, even while active.
// - Line-B polarity 1 drives B high when active, 0 drives it low.
// - Pulse mode drives active lines for at least 3 ms, then releases.
// - In pulse mode the watchdog keeps running; its flag clears at pulse end.
// - Level mode holds an active line asserted until the interrupt is cleared.
// - Watchdog mask at 1 holds the watchdog interrupt inactive.
// - Unmasked watchdog flag asserts its interrupt with current swap, polarity, mode.
// - Time-of-day mask at 1 holds the time-of-day interrupt inactive.
// - Unmasked match flag asserts its interrupt with current swap, polarity, mode.
// - Watchdog flag is set by hardware; control-byte writes leave it alone.
// - Any access to a watchdog register clears the watchdog flag; mask ignored.
// - Match flag is set on alarm match; control-byte writes leave it alone.
// - Reading any time-of-day alarm register clears the match flag; mask ignored.
// - All three alarm masks set gives one alarm every minute.
// - Only minutes unmasked gives an alarm when minutes match.
// - Minutes and hours unmasked gives an alarm when both match.
// - No alarm masks set needs minutes, hours and day to match.
// - Bit 7 of each minutes, hours and days alarm register is its mask.
// - Watchdog register access reloads the countdown, clearing flag and interrupt.
// - Both watchdog registers at zero disable the watchdog alarm.
`timescale 1ns/100ps
module alarm_irq_control
    import alarm_irq_pkg::*;
#(
    parameter int PULSE_LEN = alarm_irq_pkg::PULSE_CYCLES
)
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       ce_n,
    input  wire logic       oe_n,
    input  wire logic       we_n,
    input  wire logic [5:0] addr,
    input  wire logic [7:0] dq_in,
    output logic      [7:0] dq_out,
    output logic            dq_oe,
    input  wire logic       tick_100hz,
    input  wire logic       minute_roll,
    input  wire logic [7:0] now_minutes,
    input  wire logic [7:0] now_hours,
    input  wire logic [7:0] now_days,
    output logic            time_copy_en,
    output logic            irq_line_a,
    output logic            irq_line_a_oe,
    output logic            irq_line_b,
    output logic            irq_line_b_oe
);
    import alarm_irq_pkg::*;

    // Two-stage synchroniser on every bus pin, then a third stage for edges.
    logic [16:0] pin_s1;
    logic [16:0] pin_s2;
    logic [16:0] pin_s3;
    logic        rd_now;
    logic        rd_prev;
    logic        wr_now;
    logic        wr_prev;
    logic        rd_start;
    logic        wr_done;
    logic [5:0]  rd_addr;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;

    logic [7:0]  ctrl;
    logic [7:0]  alarm_min;
    logic [7:0]  alarm_hour;
    logic [7:0]  alarm_day;
    logic [7:0]  dog_lo;
    logic [7:0]  dog_hi;
    logic        dog_flag;
    logic        match_flag;
    logic        dog_restart;
    logic        dog_expired;

    logic        ctrl_wr;
    logic        alarm_rd;
    logic        alarm_wr;
    logic        dog_access;
    logic        match_set;
    logic        match_clr;
    logic        dog_set;
    logic        dog_clr;
    logic        min_ok;
    logic        hour_ok;
    logic        day_ok;
    logic [7:0]  read_value;
    logic [7:0]  ctrl_view;

    logic [PULSE_W-1:0] tod_tmr;
    logic [PULSE_W-1:0] dog_tmr;
    logic        pulse_mode;
    logic        tod_on;
    logic        dog_on;
    logic        next_a_on;
    logic        next_b_on;
    logic        dog_pulse_end;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= 17'h1ffff;
            pin_s2 <= 17'h1ffff;
            pin_s3 <= 17'h1ffff;
        end else begin
            pin_s1 <= {ce_n, oe_n, we_n, addr, dq_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign rd_now   = !pin_s2[16] && !pin_s2[15] && pin_s2[14];
    assign rd_prev  = !pin_s3[16] && !pin_s3[15] && pin_s3[14];
    assign wr_now   = !pin_s2[16] && !pin_s2[14];
    assign wr_prev  = !pin_s3[16] && !pin_s3[14];
    assign rd_start = rd_now && !rd_prev;
    // A write is taken when the strobe ends, with the last sampled data.
    assign wr_done  = wr_prev && !wr_now;
    assign rd_addr  = pin_s2[13:8];
    assign wr_addr  = pin_s3[13:8];
    assign wr_data  = pin_s3[7:0];

    assign ctrl_wr    = wr_done && (wr_addr == ADDR_CTRL);
    assign alarm_rd   = rd_start && ((rd_addr == ADDR_ALARM_MIN) ||
                        (rd_addr == ADDR_ALARM_HOUR) || (rd_addr == ADDR_ALARM_DAY));
    assign alarm_wr   = wr_done && ((wr_addr == ADDR_ALARM_MIN) ||
                        (wr_addr == ADDR_ALARM_HOUR) || (wr_addr == ADDR_ALARM_DAY));
    assign dog_access = (rd_start && ((rd_addr == ADDR_DOG_LO) || (rd_addr == ADDR_DOG_HI)))
                     || (wr_done && ((wr_addr == ADDR_DOG_LO) || (wr_addr == ADDR_DOG_HI)));

    // The flag bits are not stored from the bus, only shown on reads.
    assign ctrl_view  = {ctrl[7:2], dog_flag, match_flag};
    assign read_value = (rd_addr == ADDR_CTRL)       ? ctrl_view  :
                        (rd_addr == ADDR_ALARM_MIN)  ? alarm_min  :
                        (rd_addr == ADDR_ALARM_HOUR) ? alarm_hour :
                        (rd_addr == ADDR_ALARM_DAY)  ? alarm_day  :
                        (rd_addr == ADDR_DOG_LO)     ? dog_lo     :
                        (rd_addr == ADDR_DOG_HI)     ? dog_hi     : 8'h00;

    // Bit 7 of each alarm register skips its field in the compare.
    assign min_ok  = alarm_min[BIT_ALARM_MASK]  || (alarm_min[6:0]  == now_minutes[6:0]);
    assign hour_ok = alarm_hour[BIT_ALARM_MASK] || (alarm_hour[6:0] == now_hours[6:0]);
    assign day_ok  = alarm_day[BIT_ALARM_MASK]  || (alarm_day[2:0]  == now_days[2:0]);
    // Checked once per minute roll, so all masks set alarms every minute.
    assign match_set = minute_roll && min_ok && hour_ok && day_ok;

    // The host clears the match flag by reading, and also by writing, an alarm register.
    assign match_clr     = alarm_rd || alarm_wr;
    assign pulse_mode    = ctrl[BIT_PULSE_SEL];
    assign dog_pulse_end = pulse_mode && (dog_tmr == PULSE_W'(1));
    assign dog_set       = dog_expired;
    assign dog_clr       = dog_access || dog_pulse_end;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl       <= CTRL_RESET;
            alarm_min  <= ALARM_RESET;
            alarm_hour <= ALARM_RESET;
            alarm_day  <= ALARM_RESET;
            dog_lo     <= DOG_RESET;
            dog_hi     <= DOG_RESET;
        end else if (wr_done) begin
            if (wr_addr == ADDR_CTRL) begin
                ctrl <= {wr_data[7:2], 2'b00};
            end else if (wr_addr == ADDR_ALARM_MIN) begin
                alarm_min <= wr_data;
            end else if (wr_addr == ADDR_ALARM_HOUR) begin
                alarm_hour <= wr_data;
            end else if (wr_addr == ADDR_ALARM_DAY) begin
                alarm_day <= wr_data & DAY_KEEP;
            end else if (wr_addr == ADDR_DOG_LO) begin
                dog_lo <= wr_data;
            end else if (wr_addr == ADDR_DOG_HI) begin
                dog_hi <= wr_data;
            end
        end
    end

    // A set arriving with a clear wins, so no event is lost.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            match_flag <= 1'b0;
            dog_flag   <= 1'b0;
        end else begin
            match_flag <= match_set || (match_flag && !match_clr);
            dog_flag   <= dog_set || (dog_flag && !dog_clr);
        end
    end

    // Restart one cycle late so the countdown sees the newly written value.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dog_restart <= 1'b0;
        end else begin
            dog_restart <= dog_access;
        end
    end

    dog_countdown u_dog (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .tick_100hz (tick_100hz),
        .restart    (dog_restart),
        .dog_lo     (dog_lo),
        .dog_hi     (dog_hi),
        .expired    (dog_expired)
    );

    // Each source owns a pulse timer, started by its own set event.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tod_tmr <= '0;
            dog_tmr <= '0;
        end else begin
            if (pulse_mode && match_set) begin
                tod_tmr <= PULSE_W'(PULSE_LEN);
            end else if (tod_tmr != '0) begin
                tod_tmr <= tod_tmr - PULSE_W'(1);
            end
            if (dog_access) begin
                dog_tmr <= '0;
            end else if (pulse_mode && dog_set) begin
                dog_tmr <= PULSE_W'(PULSE_LEN);
            end else if (dog_tmr != '0) begin
                dog_tmr <= dog_tmr - PULSE_W'(1);
            end
        end
    end

    // Pulse mode follows the timer; level mode follows the flag until it clears.
    assign tod_on = !ctrl[BIT_TOD_MASK] &&
                    (pulse_mode ? (tod_tmr != '0) : match_flag);
    assign dog_on = !ctrl[BIT_DOG_MASK] &&
                    (pulse_mode ? (dog_tmr != '0) : dog_flag);
    // The swap steers live sources, so a change moves an active interrupt at once.
    assign next_a_on = ctrl[BIT_PIN_SWAP] ? tod_on : dog_on;
    assign next_b_on = ctrl[BIT_PIN_SWAP] ? dog_on : tod_on;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_line_a    <= 1'b1;
            irq_line_a_oe <= 1'b0;
            irq_line_b    <= 1'b1;
            irq_line_b_oe <= 1'b0;
            time_copy_en  <= 1'b0;
            dq_out        <= 8'h00;
            dq_oe         <= 1'b0;
        end else begin
            // Line A only ever sinks, and lets go when inactive.
            irq_line_a    <= 1'b0;
            irq_line_a_oe <= next_a_on;
            irq_line_b    <= ctrl[BIT_B_POLARITY];
            irq_line_b_oe <= next_b_on;
            // The counters block refreshes visible time only while this is high.
            time_copy_en  <= ctrl[BIT_COPY_ALLOW];
            dq_out        <= read_value;
            dq_oe         <= rd_now;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_swap_tod_a: assert property (
        (ctrl[BIT_PIN_SWAP] && tod_on) |=> irq_line_a_oe)
        else $error("time-of-day interrupt missing on line A");
    a_swap_dog_a: assert property (
        (!ctrl[BIT_PIN_SWAP] && dog_on) |=> irq_line_a_oe)
        else $error("watchdog interrupt missing on line A");
    a_b_level: assert property (
        irq_line_b_oe |-> (irq_line_b == $past(ctrl[BIT_B_POLARITY]) && !irq_line_a))
        else $error("line B level does not follow polarity");
    a_dog_masked: assert property (
        (ctrl[BIT_PIN_SWAP] && ctrl[BIT_DOG_MASK]) |=> !irq_line_b_oe)
        else $error("masked watchdog interrupt drives line B");
    a_tod_masked: assert property (
        (ctrl[BIT_PIN_SWAP] && ctrl[BIT_TOD_MASK]) |=> !irq_line_a_oe)
        else $error("masked time-of-day interrupt drives line A");
    a_dog_level_b: assert property (
        (ctrl[BIT_PIN_SWAP] && !ctrl[BIT_DOG_MASK] && !pulse_mode && dog_flag)
        |=> irq_line_b_oe)
        else $error("unmasked watchdog flag does not drive line B");
    a_tod_level_b: assert property (
        (!ctrl[BIT_PIN_SWAP] && !ctrl[BIT_TOD_MASK] && !pulse_mode && match_flag)
        |=> irq_line_b_oe)
        else $error("unmasked match flag does not drive line B");
    a_copy_follow: assert property (
        time_copy_en == $past(ctrl[BIT_COPY_ALLOW]))
        else $error("copy enable does not follow its control bit");
    a_flags_kept: assert property (
        (ctrl_wr && !dog_set && !match_set && !dog_clr && !match_clr) |=>
        (dog_flag == $past(dog_flag) && match_flag == $past(match_flag)))
        else $error("control write changed a flag");
    a_dog_clear: assert property (
        (dog_access && !dog_set) |=>
        (!dog_flag ##1 (!irq_line_a_oe || ctrl[BIT_PIN_SWAP])))
        else $error("watchdog access did not clear flag");
    a_dog_off: assert property (
        (dog_lo == 8'h00 && dog_hi == 8'h00) |=> !dog_expired)
        else $error("disabled watchdog expired");
    a_match_clear: assert property (
        (alarm_rd && !match_set) |=> !match_flag)
        else $error("alarm read did not clear match flag");
    a_match_set: assert property (
        (minute_roll && alarm_min[7] && alarm_hour[7] && alarm_day[7]) |=> match_flag)
        else $error("all-masked alarm did not fire on minute roll");
    a_pulse_hold: assert property (
        (pulse_mode && match_set) |=> (tod_tmr != '0) [*8])
        else $error("pulse ended too soon");
    a_pulse_end: assert property (
        (dog_pulse_end && !dog_set) |=> !dog_flag)
        else $error("watchdog flag kept after pulse end");
endmodule

// ===== inc/alarm_irq_pkg.sv
// Constants shared by the alarm and interrupt control logic.
package alarm_irq_pkg;
    localparam logic [5:0]  ADDR_ALARM_MIN  = 6'h03;
    localparam logic [5:0]  ADDR_ALARM_HOUR = 6'h05;
    localparam logic [5:0]  ADDR_ALARM_DAY  = 6'h07;
    localparam logic [5:0]  ADDR_CTRL       = 6'h0b;
    localparam logic [5:0]  ADDR_DOG_LO     = 6'h0c;
    localparam logic [5:0]  ADDR_DOG_HI     = 6'h0d;
    localparam int          BIT_COPY_ALLOW  = 7;
    localparam int          BIT_PIN_SWAP    = 6;
    localparam int          BIT_B_POLARITY  = 5;
    localparam int          BIT_PULSE_SEL   = 4;
    localparam int          BIT_DOG_MASK    = 3;
    localparam int          BIT_TOD_MASK    = 2;
    localparam int          BIT_ALARM_MASK  = 7;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  ALARM_RESET     = 8'h00;
    localparam logic [7:0]  DOG_RESET       = 8'h00;
    localparam logic [7:0]  DAY_KEEP        = 8'h87;
    localparam int          SYS_CLK_KHZ     = 50000;
    localparam int          PULSE_TIME_MS   = 3;
    localparam int          PULSE_CYCLES    = PULSE_TIME_MS * SYS_CLK_KHZ;
    localparam int          PULSE_W         = 18;
    localparam int          DOG_W           = 14;
endpackage

// ===== rtl/dog_countdown.sv
// Watchdog countdown in hundredths of a second, reloaded from two BCD bytes.
`timescale 1ns/100ps
module dog_countdown
    import alarm_irq_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       tick_100hz,
    input  wire logic       restart,
    input  wire logic [7:0] dog_lo,
    input  wire logic [7:0] dog_hi,
    output logic            expired
);
    logic [DOG_W-1:0] count;
    logic [DOG_W-1:0] reload;
    logic             enabled;

    assign reload = DOG_W'(dog_hi[7:4] * 14'd1000) + DOG_W'(dog_hi[3:0] * 14'd100)
                  + DOG_W'(dog_lo[7:4] * 14'd10) + DOG_W'(dog_lo[3:0]);
    // A zero reload switches the watchdog off entirely.
    assign enabled = (reload != '0);

    // The countdown reloads after each alarm, so it keeps running in pulse mode.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count   <= '0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (restart || !enabled) begin
                count <= reload;
            end else if (tick_100hz) begin
                if (count <= DOG_W'(1)) begin
                    count   <= reload;
                    expired <= 1'b1;
                end else begin
                    count <= count - DOG_W'(1);
                end
            end
        end
    end
endmodule

// ===== sim/host_bus_model.sv
// Host processor model for the byte-wide register port.
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic       sys_clk,
    input  wire logic       dq_oe,
    output logic            ce_n,
    output logic            oe_n,
    output logic            we_n,
    output logic      [5:0] addr,
    output logic      [7:0] dq_in
);
    initial begin
        ce_n  = 1'b1;
        oe_n  = 1'b1;
        we_n  = 1'b1;
        addr  = 6'h00;
        dq_in = 8'h00;
    end
    // Released lines flip so that a stale value can never pass for a good one.
    task automatic release_bus();
        ce_n  = 1'b1;
        oe_n  = 1'b1;
        we_n  = 1'b1;
        addr  = ~addr;
        dq_in = ~dq_in;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr  = a;
        dq_in = d;
        ce_n  = 1'b0;
        we_n  = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        release_bus();
    endtask
    task automatic rd(input logic [5:0] a);
        int n;
        n    = 0;
        addr = a;
        ce_n = 1'b0;
        oe_n = 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (dq_oe !== 1'b1 && n < 10);
        @(posedge sys_clk);
        #1;
        release_bus();
    endtask
endmodule

// ===== sim/timekeeper_alarm_irq_control_tb.sv
// Self-checking bench for the alarm and interrupt control byte.
`timescale 1ns/100ps
module timekeeper_alarm_irq_control_tb;
    import alarm_irq_pkg::*;
    // A short pulse keeps the run brief; every expectation uses this value.
    localparam int          PULSE_SIM = 20;
    localparam logic [5:0]  T_ADDR [3] = '{ADDR_ALARM_MIN, ADDR_ALARM_HOUR, ADDR_ALARM_DAY};
    localparam logic [7:0]  T_VAL  [3] = '{8'h25, 8'h12, 8'h03};
    localparam logic [23:0] T_MISS [3] = '{24'h240000, 24'h251100, 24'h251204};
    localparam logic [23:0] T_HIT  [3] = '{24'h250000, 24'h251200, 24'h251203};
    logic       sys_clk, nrst, ce_n, oe_n, we_n, dq_oe, tick_100hz, minute_roll;
    logic       time_copy_en, irq_line_a, irq_line_a_oe, irq_line_b, irq_line_b_oe;
    logic [5:0] addr;
    logic [7:0] dq_in, dq_out, now_minutes, now_hours, now_days;
    logic [7:0] exp_q [$];
    logic       prev_oe;
    int         err_count, samples_checked, run_len, last_run;

    alarm_irq_control #(.PULSE_LEN(PULSE_SIM)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .tick_100hz(tick_100hz), .minute_roll(minute_roll), .now_minutes(now_minutes),
        .now_hours(now_hours), .now_days(now_days), .time_copy_en(time_copy_en),
        .irq_line_a(irq_line_a), .irq_line_a_oe(irq_line_a_oe),
        .irq_line_b(irq_line_b), .irq_line_b_oe(irq_line_b_oe)
    );
    host_bus_model host_u (
        .sys_clk(sys_clk), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .dq_in(dq_in)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (exp_q.size() != 0)
            err_count++;
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Read data is judged on the first settled cycle of dq_oe.
    always @(negedge sys_clk) begin
        if (dq_oe === 1'b1 && prev_oe !== 1'b1) begin
            if (exp_q.size() > 0)
                check("read data", dq_out, exp_q.pop_front());
            else
                check("unasked read", 8'h00, 8'h01);
        end
        prev_oe = dq_oe;
    end

    always @(posedge sys_clk) begin
        if (irq_line_b_oe === 1'b1)
            run_len <= run_len + 1;
        else begin
            if (run_len != 0)
                last_run <= run_len;
            run_len <= 0;
        end
    end

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            tick_100hz = 1'b1;
            @(posedge sys_clk);
            #1;
            tick_100hz = 1'b0;
            repeat (3) @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic roll(input logic [23:0] t);
        now_minutes = t[23:16];
        now_hours   = t[15:8];
        now_days    = t[7:0];
        minute_roll = 1'b1;
        @(posedge sys_clk);
        #1;
        minute_roll = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic lines(input logic a_oe, input logic b_oe, input logic b);
        check("line a enable", 8'(irq_line_a_oe), 8'(a_oe));
        check("line b enable", 8'(irq_line_b_oe), 8'(b_oe));
        if (b_oe)
            check("line b level", 8'(irq_line_b), 8'(b));
        if (a_oe)
            check("line a level", 8'(irq_line_a), 8'h00);
    endtask

    initial begin
        #400000;
        err_count++;
        close_out();
    end

    initial begin
        logic [7:0] r;
        nrst        = 1'b0;
        tick_100hz  = 1'b0;
        minute_roll = 1'b0;
        now_minutes = 8'h00;
        now_hours   = 8'h00;
        now_days    = 8'h00;
        prev_oe     = 1'b0;
        run_len     = 0;
        last_run    = 0;
        err_count   = 0;
        samples_checked = 0;
        void'($urandom(25840));
        repeat (16) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        rd_chk(ADDR_CTRL, CTRL_RESET);
        rd_chk(6'h3f, 8'h00);
        for (int i = 0; i < 4; i++) begin
            // Both masks stay set so that no line moves during this loop.
            r = 8'($urandom()) | 8'h0c;
            host_u.wr(ADDR_CTRL, r | 8'h03);
            check("copy enable", 8'(time_copy_en), 8'(r[7]));
            rd_chk(ADDR_CTRL, r & 8'hfc);
        end
        host_u.wr(ADDR_CTRL, 8'h28);
        host_u.wr(ADDR_ALARM_MIN, 8'h80);
        host_u.wr(ADDR_ALARM_HOUR, 8'h80);
        host_u.wr(ADDR_ALARM_DAY, 8'hff);
        rd_chk(ADDR_ALARM_DAY, 8'h87);
        roll({8'($urandom_range(0, 59)), 16'h0000});
        lines(1'b0, 1'b1, 1'b1);
        repeat (10) @(posedge sys_clk);
        #1;
        lines(1'b0, 1'b1, 1'b1);
        host_u.wr(ADDR_CTRL, 8'h68);
        lines(1'b1, 1'b0, 1'b0);
        host_u.wr(ADDR_CTRL, 8'h6c);
        lines(1'b0, 1'b0, 1'b0);
        rd_chk(ADDR_CTRL, 8'h6d);
        host_u.wr(ADDR_CTRL, 8'h08);
        for (int i = 0; i < 3; i++) begin
            host_u.wr(T_ADDR[i], T_VAL[i]);
            roll(T_MISS[i]);
            rd_chk(ADDR_CTRL, 8'h08);
            roll(T_HIT[i]);
            lines(1'b0, 1'b1, 1'b0);
            rd_chk(ADDR_CTRL, 8'h09);
        end
        rd_chk(ADDR_ALARM_DAY, 8'h03);
        rd_chk(ADDR_CTRL, 8'h08);
        host_u.wr(ADDR_CTRL, 8'h64);
        host_u.wr(ADDR_DOG_LO, 8'h03);
        host_u.wr(ADDR_DOG_HI, 8'h00);
        tick(4);
        lines(1'b0, 1'b1, 1'b1);
        host_u.wr(ADDR_CTRL, 8'h24);
        lines(1'b1, 1'b0, 1'b0);
        host_u.wr(ADDR_CTRL, 8'h6c);
        lines(1'b0, 1'b0, 1'b0);
        rd_chk(ADDR_CTRL, 8'h6e);
        rd_chk(ADDR_DOG_LO, 8'h03);
        rd_chk(ADDR_CTRL, 8'h6c);
        host_u.wr(ADDR_CTRL, 8'h74);
        roll(T_HIT[2]);
        rd_chk(ADDR_CTRL, 8'h75);
        rd_chk(ADDR_ALARM_MIN, 8'h25);
        host_u.wr(ADDR_DOG_LO, 8'h03);
        tick(4);
        repeat (PULSE_SIM + 5) @(posedge sys_clk);
        #1;
        check("pulse length", 8'(last_run), 8'(PULSE_SIM));
        rd_chk(ADDR_CTRL, 8'h74);
        host_u.wr(ADDR_DOG_LO, 8'h00);
        tick(8);
        rd_chk(ADDR_CTRL, 8'h74);
        close_out();
    end
endmodule
